// ===== core/kms_key_scan.v
// Key matrix scan controller sharing sixteen segment pins with scan drive
//
// Contract
// - Power-on reset or clock stop: segment mode, all pins and backplanes low.
// - CE reset and halt: segments keep waveforms, port pins hold, backplanes run.
// - Sixteen drive pins crossed with four return inputs scan up to 64 keys.
// - Scan drive and segment levels use separate time slots, never mixed.
// - Scan data register loads from CPU data and drives pins in scan slots.
// - In port mode the scan data register supplies static pin values.
// - Display off suppresses scan drive and drives segment pins low.
// - Mode register holds separate display-on and scan-enable controls.
// - Port select chooses segment output or general-purpose port output.
// - Scan drive appears only while pins are in segment mode.
// - Return inputs are sampled only during scan slots.
// - While scanning, return pins act as key inputs, not analog inputs.
// - Sampled keys are readable at data address 73H, bank 0.
// - Scan slot lasts 220 us every 4 ms, drive follows loaded bits.
// - Scan complete flag sets after full slot, clears on data write or read.
// - Port select one makes pins ports, port output has precedence.
// - Scan output needs port select zero, display on and scan enable one.
`timescale 1ns/1ns
`include "kms_regs.vh"
module kms_key_scan #(
    parameter SLOT_CYC = `KMS_SLOT_CYC,
    parameter FRAME_CYC = `KMS_FRAME_CYC
) (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire clock_stop_in,
    input wire hold_in,
    input wire wr_en_in,
    input wire rd_en_in,
    input wire [6:0] addr_in,
    input wire [15:0] wr_data_in,
    input wire [15:0] seg_data_in,
    input wire [13:0] seg_extra_in,
    input wire backplane_wave_1_in,
    input wire backplane_wave_0_in,
    input wire [3:0] key_return_in,
    output reg [15:0] rd_data_out,
    output reg [15:0] shared_output_port_out,
    output reg [13:0] seg_extra_out,
    output reg backplane_out_1_out,
    output reg backplane_out_0_out,
    output reg key_pulldown_out,
    output reg adc_path_en_out
);
    // ==========================================================
    // Reset release
    reg rst_s1_q;
    reg rst_s2_q;
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // ==========================================================
    // Pin synchronisers, a change counts once stages two and three agree
    reg [3:0] key_s1_q;
    reg [3:0] key_s2_q;
    reg [3:0] key_s3_q;
    reg [3:0] key_stable_q;
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            key_s1_q <= `KMS_RST_KEYS;
            key_s2_q <= `KMS_RST_KEYS;
            key_s3_q <= `KMS_RST_KEYS;
            key_stable_q <= `KMS_RST_KEYS;
        end else begin
            key_s1_q <= key_return_in;
            key_s2_q <= key_s1_q;
            key_s3_q <= key_s2_q;
            if (key_s2_q == key_s3_q) begin
                key_stable_q <= key_s3_q;
            end
        end
    end

    // ==========================================================
    // Registers
    reg [15:0] scan_drive_data_reg_q;
    reg [1:0] display_mode_reg_q;
    reg port_select_flag_q;
    reg scan_complete_flag_q;
    reg [3:0] key_input_sample_port_q;
    wire display_on_flag = display_mode_reg_q[`KMS_BIT_DISP_ON];
    wire scan_enable_flag = display_mode_reg_q[`KMS_BIT_SCAN_EN];

    function hit;
        input [6:0] a;
        input [6:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    // A halted CPU issues no writes; a stray strobe must not move held port pins
    wire wr_ok = wr_en_in && !hold_in;
    wire wr_scan = wr_ok && hit(addr_in, `KMS_ADDR_SCAN_DATA);
    wire rd_judge = rd_en_in && hit(addr_in, `KMS_ADDR_JUDGE);
    // Scan output only in segment mode with display and scan both on
    wire scan_allowed = !port_select_flag_q && display_on_flag && scan_enable_flag;

    // ==========================================================
    // Slot and frame timing
    reg [31:0] frame_cnt_q;
    wire frame_wrap = (frame_cnt_q == FRAME_CYC - 1);
    wire in_slot = scan_allowed && (frame_cnt_q < SLOT_CYC);
    wire slot_end = scan_allowed && (frame_cnt_q == SLOT_CYC - 1);
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            frame_cnt_q <= 32'h0;
        end else if (clock_stop_in || !scan_allowed) begin
            frame_cnt_q <= 32'h0;
        end else if (frame_wrap) begin
            frame_cnt_q <= 32'h0;
        end else begin
            frame_cnt_q <= frame_cnt_q + 32'h1;
        end
    end

    // ==========================================================
    // Register writes and flags; hold blocks writes, but clock stop still resets mode and port select
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            scan_drive_data_reg_q <= `KMS_RST_SCAN_DATA;
            display_mode_reg_q <= `KMS_RST_MODE;
            port_select_flag_q <= 1'b0;
            scan_complete_flag_q <= 1'b0;
            key_input_sample_port_q <= `KMS_RST_KEYS;
        end else if (clock_stop_in) begin
            display_mode_reg_q <= `KMS_RST_MODE;
            port_select_flag_q <= 1'b0;
            scan_complete_flag_q <= 1'b0;
        end else begin
            if (wr_scan) begin
                scan_drive_data_reg_q <= wr_data_in;
            end
            if (wr_ok && hit(addr_in, `KMS_ADDR_MODE)) begin
                display_mode_reg_q <= wr_data_in[1:0];
            end
            if (wr_ok && hit(addr_in, `KMS_ADDR_PORT_SEL)) begin
                port_select_flag_q <= wr_data_in[`KMS_BIT_PORT_SEL];
            end
            // Set wins over a clear in the same cycle so a slot end is not lost
            if (slot_end) begin
                scan_complete_flag_q <= 1'b1;
            end else if (wr_scan || rd_judge) begin
                scan_complete_flag_q <= 1'b0;
            end
            if (slot_end) begin
                key_input_sample_port_q <= key_stable_q;
            end
        end
    end

    // ==========================================================
    // Read port
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_out <= 16'h0000;
        end else if (rd_en_in) begin
            if (hit(addr_in, `KMS_ADDR_KEY_PORT)) begin
                rd_data_out <= {12'h000, key_input_sample_port_q};
            end else if (rd_judge) begin
                rd_data_out <= {15'h0000, scan_complete_flag_q};
            end else if (hit(addr_in, `KMS_ADDR_SCAN_DATA)) begin
                rd_data_out <= scan_drive_data_reg_q;
            end else if (hit(addr_in, `KMS_ADDR_MODE)) begin
                rd_data_out <= {14'h0000, display_mode_reg_q};
            end else if (hit(addr_in, `KMS_ADDR_PORT_SEL)) begin
                rd_data_out <= {15'h0000, port_select_flag_q};
            end else begin
                rd_data_out <= 16'h0000;
            end
        end
    end

    // ==========================================================
    // Pin drive; port takes precedence, then display off, then slot
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            shared_output_port_out <= 16'h0000;
            seg_extra_out <= 14'h0000;
            backplane_out_1_out <= 1'b0;
            backplane_out_0_out <= 1'b0;
            key_pulldown_out <= 1'b0;
            adc_path_en_out <= 1'b1;
        end else if (clock_stop_in) begin
            shared_output_port_out <= 16'h0000;
            seg_extra_out <= 14'h0000;
            backplane_out_1_out <= 1'b0;
            backplane_out_0_out <= 1'b0;
            key_pulldown_out <= 1'b0;
            adc_path_en_out <= 1'b1;
        end else begin
            // Hold freezes nothing here: segments and backplanes keep running
            backplane_out_1_out <= display_on_flag && backplane_wave_1_in;
            backplane_out_0_out <= display_on_flag && backplane_wave_0_in;
            key_pulldown_out <= in_slot;
            adc_path_en_out <= !scan_allowed;
            if (port_select_flag_q) begin
                shared_output_port_out <= scan_drive_data_reg_q;
            end else if (!display_on_flag) begin
                shared_output_port_out <= 16'h0000;
            end else if (in_slot) begin
                shared_output_port_out <= scan_drive_data_reg_q;
            end else begin
                shared_output_port_out <= seg_data_in;
            end
            if (!display_on_flag || in_slot) begin
                seg_extra_out <= 14'h0000;
            end else begin
                seg_extra_out <= seg_extra_in;
            end
        end
    end
endmodule

// ===== include/kms_regs.vh
// Register addresses, field positions, reset values and timing constants of the key scan controller
`ifndef KMS_REGS_VH
`define KMS_REGS_VH
`define KMS_ADDR_KEY_PORT 7'h73
`define KMS_ADDR_SCAN_DATA 7'h42
`define KMS_ADDR_MODE 7'h40
`define KMS_ADDR_PORT_SEL 7'h41
`define KMS_ADDR_JUDGE 7'h16
`define KMS_BIT_DISP_ON 0
`define KMS_BIT_SCAN_EN 1
`define KMS_BIT_PORT_SEL 0
`define KMS_BIT_SCAN_DONE 0
`define KMS_RST_SCAN_DATA 16'h0000
`define KMS_RST_KEYS 4'h0
`define KMS_RST_MODE 2'h0
`define KMS_CLK_HZ 20000000
`define KMS_SLOT_US 220
`define KMS_FRAME_MS 4
`define KMS_SLOT_CYC ((`KMS_SLOT_US * (`KMS_CLK_HZ / 1000000)))
`define KMS_FRAME_CYC ((`KMS_FRAME_MS * (`KMS_CLK_HZ / 1000)))
`endif

// ===== tb/kms_key_scan_checker.sv
// Port-level assertions for the key scan controller
`timescale 1ns/1ns
module kms_key_scan_checker #(parameter SLOT_CYC = 8, parameter FRAME_CYC = 40) (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire clock_stop_in,
    input wire rd_en_in,
    input wire [6:0] addr_in,
    input wire [15:0] rd_data_out,
    input wire [15:0] shared_output_port_out,
    input wire [13:0] seg_extra_out,
    input wire backplane_out_1_out,
    input wire backplane_out_0_out,
    input wire key_pulldown_out,
    input wire adc_path_en_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    logic [15:0] run_q;
    logic armed_q;
    // The first slot after enabling starts at frame count zero, but only slots after a completed one are timed
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run_q <= 16'h0000;
            armed_q <= 1'b0;
        end else begin
            run_q <= key_pulldown_out ? run_q + 16'h0001 : 16'h0000;
            armed_q <= adc_path_en_out ? 1'b0 : (armed_q | (run_q != 16'h0000 && !key_pulldown_out));
        end
    end
    a_stop_blanks: assert property (clock_stop_in [*2] |-> shared_output_port_out == 16'h0000
        && seg_extra_out == 14'h0000 && !backplane_out_1_out && !backplane_out_0_out) else $error("stop not blank");
    a_slot_extra_low: assert property (key_pulldown_out |-> seg_extra_out == 14'h0000) else $error("extra pins busy");
    a_slot_key_mode: assert property (key_pulldown_out |-> !adc_path_en_out) else $error("adc path in slot");
    // A slot cut short by disabling scan or clock stop shows the converter path at once, so it is not timed
    a_slot_length: assert property ($fell(key_pulldown_out) && armed_q && !adc_path_en_out
        |-> run_q == SLOT_CYC) else $error("slot length");
    a_read_holds: assert property (!$past(rd_en_in) |-> $stable(rd_data_out)) else $error("read data moved");
    a_unmapped_zero: assert property (rd_en_in && !(addr_in inside {7'h16, 7'h40, 7'h41, 7'h42, 7'h73})
        |=> rd_data_out == 16'h0000) else $error("unmapped read");
    a_key_port_width: assert property (rd_en_in && addr_in == 7'h73 |=> rd_data_out[15:4] == 12'h000) else $error("key width");
    a_judge_width: assert property (rd_en_in && addr_in == 7'h16 |=> rd_data_out[15:1] == 15'h0000) else $error("judge width");
endmodule
bind kms_key_scan kms_key_scan_checker #(.SLOT_CYC(SLOT_CYC), .FRAME_CYC(FRAME_CYC)) u_chk (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clock_stop_in(clock_stop_in), .rd_en_in(rd_en_in),
    .addr_in(addr_in), .rd_data_out(rd_data_out), .shared_output_port_out(shared_output_port_out),
    .seg_extra_out(seg_extra_out), .backplane_out_1_out(backplane_out_1_out),
    .backplane_out_0_out(backplane_out_0_out), .key_pulldown_out(key_pulldown_out),
    .adc_path_en_out(adc_path_en_out));

// ===== tb/kms_key_matrix.sv
// Passive key switch matrix on the scan drive and return pins
`timescale 1ns/1ns
module kms_key_matrix (
    input wire clk_sys_in,
    input wire [63:0] pressed_in,
    input wire [15:0] drive_in,
    input wire pulldown_in,
    output logic [3:0] return_out
);
    logic [3:0] churn_q = 4'h5;
    always @(posedge clk_sys_in) churn_q <= churn_q + 4'h3;
    // Lines float outside slots, so show a moving pattern instead of a stale level
    always_comb begin
        return_out = churn_q;
        if (pulldown_in) begin
            return_out = 4'h0;
            for (int i = 0; i < 16; i++)
                if (drive_in[i]) return_out = return_out | pressed_in[i*4 +: 4];
        end
    end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the key scan controller
`timescale 1ns/1ns
module tb_top;
    localparam int FRAME = 40;
    logic clk_sys_in = 0, resetn_in = 0, clock_stop_in = 0, hold_in = 0, wr_en_in = 0, rd_en_in = 0;
    logic [6:0] addr_in = 7'h00;
    logic [15:0] wr_data_in = 16'h0000, seg_data_in = 16'h0000, rd_data_out, shared_output_port_out, kd, got;
    logic [13:0] seg_extra_in = 14'h0000, seg_extra_out;
    logic backplane_wave_1_in = 1, backplane_wave_0_in = 1, backplane_out_1_out, backplane_out_0_out;
    logic key_pulldown_out, adc_path_en_out;
    logic [3:0] key_return_in, ek;
    logic [63:0] pressed = 64'h0;
    int err_total = 0, checks = 0;
    kms_key_scan #(.SLOT_CYC(8), .FRAME_CYC(FRAME)) u_dut (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clock_stop_in(clock_stop_in), .hold_in(hold_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .seg_data_in(seg_data_in), .seg_extra_in(seg_extra_in), .backplane_wave_1_in(backplane_wave_1_in),
        .backplane_wave_0_in(backplane_wave_0_in), .key_return_in(key_return_in), .rd_data_out(rd_data_out),
        .shared_output_port_out(shared_output_port_out), .seg_extra_out(seg_extra_out),
        .backplane_out_1_out(backplane_out_1_out), .backplane_out_0_out(backplane_out_0_out),
        .key_pulldown_out(key_pulldown_out), .adc_path_en_out(adc_path_en_out));
    kms_key_matrix u_keys (.clk_sys_in(clk_sys_in), .pressed_in(pressed), .drive_in(shared_output_port_out),
        .pulldown_in(key_pulldown_out), .return_out(key_return_in));
    initial forever #25 clk_sys_in = ~clk_sys_in;
    task automatic cmp(input logic [15:0] g, input logic [15:0] e, input string what);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
        end
    endtask
    task automatic cyc;
        @(posedge clk_sys_in);
        #2;
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        cyc();
        {wr_en_in, addr_in, wr_data_in} = {1'b1, a, d};
        cyc();
        wr_en_in = 0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        cyc();
        {rd_en_in, addr_in} = {1'b1, a};
        cyc();
        rd_en_in = 0;
        cmp(rd_data_out, e, "read");
    endtask
    task automatic slot_end;
        int n = 0;
        while (key_pulldown_out !== 1'b1 && n < 200) begin cyc(); n++; end
        while (key_pulldown_out === 1'b1 && n < 200) begin cyc(); n++; end
        cmp(16'(n < 200), 16'h0001, "slot wait");
    endtask
    task automatic watch(input logic [15:0] in_slot, input logic [15:0] off_slot, input int want, input bit disp);
        int seen = 0;
        logic [1:0] wv;
        logic slot;
        repeat (FRAME) begin
            wv = {backplane_wave_1_in, backplane_wave_0_in};
            cyc();
            slot = (key_pulldown_out === 1'b1);
            seen += slot;
            cmp(shared_output_port_out, slot ? in_slot : off_slot, "pins");
            cmp({14'h0, backplane_out_1_out, backplane_out_0_out}, {14'h0, disp ? wv : 2'b00}, "backplane");
            cmp({2'b00, seg_extra_out}, (disp && !slot) ? {2'b00, seg_extra_in} : 16'h0000, "extra");
            {backplane_wave_1_in, backplane_wave_0_in} = 2'($urandom);
        end
        cmp(16'(seen), 16'(want), "slot cycles");
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #500000;
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32));
        seg_data_in = 16'($urandom);
        seg_extra_in = 14'($urandom);
        repeat (5) @(posedge clk_sys_in);
        #2 resetn_in = 1;
        repeat (3) cyc();
        cmp(shared_output_port_out | {2'b00, seg_extra_out} | {14'h0, backplane_out_1_out, backplane_out_0_out},
            16'h0000, "reset");
        rd(7'h73, 16'h0000);
        rd(7'h05, 16'h0000);
        $display("test reset done");
        kd = 16'($urandom);
        wr(7'h41, 16'h0001);
        wr(7'h40, 16'h0003);
        wr(7'h42, kd);
        hold_in = 1;
        wr(7'h42, ~kd);
        watch(kd, kd, 0, 1);
        rd(7'h42, kd);
        rd(7'h40, 16'h0003);
        rd(7'h41, 16'h0001);
        hold_in = 0;
        $display("test port mode done");
        wr(7'h41, 16'h0000);
        repeat (4) begin
            slot_end();
            kd = 16'($urandom);
            pressed = {$urandom, $urandom};
            ek = 4'h0;
            for (int i = 0; i < 16; i++) if (kd[i]) ek |= pressed[i*4 +: 4];
            wr(7'h42, kd);
            rd(7'h16, 16'h0000);
            slot_end();
            rd(7'h16, 16'h0001);
            rd(7'h16, 16'h0000);
            rd(7'h73, {12'h000, ek});
            watch(kd, seg_data_in, 8, 1);
        end
        $display("test scan done");
        slot_end();
        wr(7'h40, 16'h0002);
        watch(16'h0000, 16'h0000, 0, 0);
        wr(7'h40, 16'h0001);
        watch(seg_data_in, seg_data_in, 0, 1);
        $display("test mode done");
        clock_stop_in = 1;
        repeat (3) cyc();
        cmp(shared_output_port_out | {2'b00, seg_extra_out} | {14'h0, backplane_out_1_out, backplane_out_0_out},
            16'h0000, "stop");
        clock_stop_in = 0;
        watch(16'h0000, 16'h0000, 0, 0);
        $display("test clock stop done");
        end_of_test();
    end
endmodule
